/* hdl/lhs_top.v */
// Behaviour
// - Interrupt when flag set and enable set
// - Flag clears by status then control3 read
// - Method zero: break alone is header
// - Method one: break, synch, identifier
// - Synch state set on break, hardware clears
// - Software clearing synch state returns idle
// - Auto synch counts receive falling edges
// - Mantissa is divider integer, zero stops
// - Zero mantissa stops transmit, receive clocks
// - Fraction low nibble, upper bits zero
// - Divider applied only on mantissa write
// - Divider registers at baud, prescaler addresses
// - Length readable only with auto or method
// - Length loaded all ones on break, method one only
// - Length loaded zero on timeout
// - Length loaded with code at header
// - Code is 57 minus duration, quarters
// - Fraction rounding carries into integer
// - Slave mode needs both bits, 11-bit break
`include "lhs_defines.vh"

module lhs_top #(
  parameter [11:0] HDR_TIMEOUT_TICKS = 12'h4c0
) (
  input  wire       clk,
  input  wire       srst,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  input  wire       serial_rx_input,
  output reg        sci_irq,
  output reg        tx_clk_on,
  output reg        rx_clk_on
);

  // Header tracking states
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_BREAK  = 7'h02;
  localparam [6:0] ST_BRKEND = 7'h04;
  localparam [6:0] ST_SYNCH  = 7'h08;
  localparam [6:0] ST_SYNCB  = 7'h10;
  localparam [6:0] ST_IDWAIT = 7'h20;
  localparam [6:0] ST_IDBYTE = 7'h40;

  // Address match for one register
  function hit;
    input [2:0] a;
    input [2:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Quarter-bit coding of the header duration
  function [7:0] hdr_code;
    input [11:0] t;
    reg   [12:0] r;
    reg   [10:0] q;
    reg   [10:0] d;
    begin
      // Half a quarter added, so 2/4 carries up
      r = {1'b0, t} + `LHS_QROUND;
      q = r[12:2];
      d = `LHS_HDR_MAX_Q - q;
      if (q >= `LHS_HDR_MAX_Q)
        hdr_code = `LHS_ZERO8;
      else
        hdr_code = d[7:0];
    end
  endfunction

  // Control bits of the third control register
  reg         divider_update_reg;     // Stored only
  reg         lin_enable_reg;         // LIN mode on
  reg         slave_select_reg;       // Slave role
  reg         auto_synch_enable_reg;  // Edge counting
  reg         header_method_select_reg; // Header kind
  reg         header_irq_enable_reg;  // Irq gate
  reg         header_detect_flag_reg; // Sticky flag
  reg         synch_field_state_reg;  // Synch analysis

  // Divider and prescaler storage
  reg  [7:0]  divider_mantissa_reg;   // Integer part
  reg  [3:0]  divider_fraction_reg;   // Sixteenths
  reg  [11:0] slave_baud_divider_reg; // Active divider
  reg  [7:0]  baud_rate_reg;          // Plain mode
  reg  [7:0]  ext_tx_prescaler_reg;   // Plain mode
  reg  [7:0]  ext_rx_prescaler_reg;   // Plain mode
  reg  [7:0]  header_length_reg;      // Measured code

  // Clear sequence and header tracking
  reg         clr_armed_reg;          // Status seen
  reg  [6:0]  state_reg;              // Current state
  reg  [6:0]  state_next;             // Next state
  reg  [7:0]  low_cnt_reg;            // Break ticks
  reg  [7:0]  chr_cnt_reg;            // Char ticks
  reg  [2:0]  edge_cnt_reg;           // Synch edges
  reg  [11:0] hdr_cnt_reg;            // Header ticks
  reg         rx_d_reg;               // Last sample

  // Event strobes from the state logic
  reg         brk_evt;                // Break found
  reg         id_evt;                 // Identifier ok
  reg         sf_done;                // Synch finished
  reg         tmo_evt;                // Header too long

  wire        rx_s;                   // Synchronised pin
  wire        tick;                   // Sample tick
  wire        lin_slave;              // Slave mode on
  wire        fall;                   // Falling edge
  wire        hdr_det;                // Header found
  wire        sw_lsf_clr;             // Software exit
  wire        lhl_open;               // Length visible
  wire        wr_cr3;                 // Control3 write
  wire        rd_cr3;                 // Control3 read
  wire        acc_status;             // Status access

  // Slave mode needs both mode bits
  assign lin_slave = lin_enable_reg & slave_select_reg;

  // Edge seen between two tick samples
  assign fall = tick & rx_d_reg & ~rx_s;

  // Method picks break or identifier as header
  assign hdr_det = id_evt |
                   (brk_evt & ~header_method_select_reg);

  assign wr_cr3     = wr_en & hit(addr, `LHS_OFF_CR3);
  assign rd_cr3     = rd_en & hit(addr, `LHS_OFF_CR3);
  assign acc_status = (wr_en | rd_en) & hit(addr, `LHS_OFF_STATUS);

  // Writing zero to the synch bit leaves analysis
  assign sw_lsf_clr = wr_cr3 & ~wdata[`LHS_CR3_SF] &
                      synch_field_state_reg;

  // Length register visible only in these modes
  assign lhl_open = lin_slave &
                    (auto_synch_enable_reg |
                     header_method_select_reg);

  // Pin passes two flops before use
  lhs_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (serial_rx_input),
    .dout (rx_s)
  );

  // Oversampling clock from the active divider
  lhs_baud u_baud (
    .clk     (clk),
    .srst    (srst),
    .divider (slave_baud_divider_reg),
    .tick    (tick)
  );

  // Next state and header events
  always @* begin
    state_next = state_reg;
    brk_evt    = 1'b0;
    id_evt     = 1'b0;
    sf_done    = 1'b0;
    tmo_evt    = 1'b0;
    if (!lin_slave || sw_lsf_clr) begin
      // Mode off or software exit
      state_next = ST_IDLE;
    end else if (state_reg != ST_IDLE &&
                 state_reg != ST_BREAK &&
                 hdr_cnt_reg >= HDR_TIMEOUT_TICKS) begin
      // Header ran past its limit
      tmo_evt    = 1'b1;
      state_next = ST_IDLE;
    end else if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          // Dominant level may open a break
          if (!rx_s)
            state_next = ST_BREAK;
        end
        ST_BREAK: begin
          if (rx_s) begin
            // Too short for a break
            state_next = ST_IDLE;
          end else if (low_cnt_reg == `LHS_BREAK_LAST) begin
            // Eleven dominant bits seen
            brk_evt    = 1'b1;
            state_next = ST_BRKEND;
          end
        end
        ST_BRKEND: begin
          // Wait for the break delimiter
          if (rx_s)
            state_next = ST_SYNCH;
        end
        ST_SYNCH: begin
          if (fall && auto_synch_enable_reg) begin
            // Count edges of the synch byte
            if (edge_cnt_reg == `LHS_SYNCH_EDGES - 3'h1) begin
              sf_done    = 1'b1;
              state_next = header_method_select_reg ?
                           ST_IDWAIT : ST_IDLE;
            end
          end else if (fall) begin
            // Without auto synch, time the byte
            state_next = ST_SYNCB;
          end
        end
        ST_SYNCB: begin
          if (chr_cnt_reg == `LHS_CHAR_TICKS) begin
            sf_done    = 1'b1;
            state_next = header_method_select_reg ?
                         ST_IDWAIT : ST_IDLE;
          end
        end
        ST_IDWAIT: begin
          // Start bit of the identifier
          if (fall)
            state_next = ST_IDBYTE;
        end
        ST_IDBYTE: begin
          if (chr_cnt_reg == `LHS_CHAR_TICKS) begin
            // Good stop bit ends the header
            id_evt     = rx_s;
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // State, counters and sample history
  always @(posedge clk) begin
    if (srst) begin
      state_reg    <= ST_IDLE;
      low_cnt_reg  <= `LHS_ZERO8;
      chr_cnt_reg  <= `LHS_ZERO8;
      edge_cnt_reg <= 3'h0;
      hdr_cnt_reg  <= `LHS_ZERO12;
      rx_d_reg     <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (tick)
        rx_d_reg <= rx_s;
      // Dominant ticks inside a break
      if (state_next != ST_BREAK)
        low_cnt_reg <= `LHS_ZERO8;
      else if (tick)
        low_cnt_reg <= low_cnt_reg + 8'h01;
      // Ticks since a character start bit
      if (state_next != state_reg)
        chr_cnt_reg <= `LHS_ZERO8;
      else if (tick)
        chr_cnt_reg <= chr_cnt_reg + 8'h01;
      // Falling edges in the synch byte
      if (state_reg != ST_SYNCH)
        edge_cnt_reg <= 3'h0;
      else if (fall)
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      // Header duration, saturating
      if (state_next == ST_IDLE)
        hdr_cnt_reg <= `LHS_ZERO12;
      else if (tick && hdr_cnt_reg != `LHS_ONES12)
        hdr_cnt_reg <= hdr_cnt_reg + 12'h001;
    end
  end

  // Register file, flags and length register
  always @(posedge clk) begin
    if (srst) begin
      divider_update_reg       <= 1'b0;
      lin_enable_reg           <= 1'b0;
      slave_select_reg         <= 1'b0;
      auto_synch_enable_reg    <= 1'b0;
      header_method_select_reg <= 1'b0;
      header_irq_enable_reg    <= 1'b0;
      header_detect_flag_reg   <= 1'b0;
      synch_field_state_reg    <= 1'b0;
      divider_mantissa_reg     <= `LHS_ZERO8;
      divider_fraction_reg     <= `LHS_ZERO4;
      slave_baud_divider_reg   <= `LHS_ZERO12;
      baud_rate_reg            <= `LHS_ZERO8;
      ext_tx_prescaler_reg     <= `LHS_ZERO8;
      ext_rx_prescaler_reg     <= `LHS_ZERO8;
      header_length_reg        <= `LHS_ZERO8;
      clr_armed_reg            <= 1'b0;
    end else begin
      // Software-owned control bits
      if (wr_cr3) begin
        divider_update_reg       <= wdata[`LHS_CR3_UPD];
        lin_enable_reg           <= wdata[`LHS_CR3_LIN];
        slave_select_reg         <= wdata[`LHS_CR3_SLV];
        auto_synch_enable_reg    <= wdata[`LHS_CR3_ASE];
        header_method_select_reg <= wdata[`LHS_CR3_HDM];
        header_irq_enable_reg    <= wdata[`LHS_CR3_HIE];
      end
      // Mantissa write applies both parts
      if (wr_en && hit(addr, `LHS_OFF_BAUD)) begin
        if (lin_slave) begin
          divider_mantissa_reg   <= wdata;
          slave_baud_divider_reg <= {wdata,
                                     divider_fraction_reg};
        end else begin
          baud_rate_reg <= wdata;
        end
      end
      // Fraction is held until the mantissa write
      if (wr_en && hit(addr, `LHS_OFF_ETX)) begin
        if (lin_slave)
          divider_fraction_reg <= wdata[3:0];
        else
          ext_tx_prescaler_reg <= wdata;
      end
      // Plain prescaler only outside slave mode
      if (wr_en && hit(addr, `LHS_OFF_ERX) && !lin_slave)
        ext_rx_prescaler_reg <= wdata;
      // Status access arms the flag clear
      if (acc_status)
        clr_armed_reg <= 1'b1;
      else if (rd_cr3)
        clr_armed_reg <= 1'b0;
      // Detection wins over the clear
      if (hdr_det)
        header_detect_flag_reg <= 1'b1;
      else if (rd_cr3 && clr_armed_reg)
        header_detect_flag_reg <= 1'b0;
      // Synch state: set on break wins
      if (brk_evt)
        synch_field_state_reg <= 1'b1;
      else if (sf_done || tmo_evt || sw_lsf_clr || !lin_slave)
        synch_field_state_reg <= 1'b0;
      // Length: header, timeout, then break
      if (hdr_det)
        header_length_reg <= hdr_code(hdr_cnt_reg);
      else if (tmo_evt)
        header_length_reg <= `LHS_ZERO8;
      else if (brk_evt)
        header_length_reg <= `LHS_ONES8;
    end
  end

  // Read data valid only in the cycle after
  always @(posedge clk) begin
    if (srst || !rd_en) begin
      rdata <= `LHS_ZERO8;
    end else begin
      case (addr)
        `LHS_OFF_CR3: begin
          rdata <= {divider_update_reg, lin_enable_reg,
                    slave_select_reg, auto_synch_enable_reg,
                    header_method_select_reg, header_irq_enable_reg,
                    header_detect_flag_reg, synch_field_state_reg};
        end
        `LHS_OFF_BAUD: begin
          rdata <= lin_slave ? divider_mantissa_reg :
                               baud_rate_reg;
        end
        `LHS_OFF_ETX: begin
          // Reserved upper nibble reads zero
          rdata <= lin_slave ? {`LHS_ZERO4, divider_fraction_reg} :
                               ext_tx_prescaler_reg;
        end
        `LHS_OFF_ERX: begin
          if (lhl_open)
            rdata <= header_length_reg;
          else if (lin_slave)
            rdata <= `LHS_ZERO8;
          else
            rdata <= ext_rx_prescaler_reg;
        end
        default: begin
          // Status and unmapped read zero
          rdata <= `LHS_ZERO8;
        end
      endcase
    end
  end

  // Interrupt and clock gates
  always @(posedge clk) begin
    if (srst) begin
      sci_irq   <= 1'b0;
      tx_clk_on <= 1'b0;
      rx_clk_on <= 1'b0;
    end else begin
      sci_irq   <= lin_slave & header_irq_enable_reg &
                   header_detect_flag_reg;
      // Zero mantissa stops both directions
      tx_clk_on <= ~lin_slave |
                   (divider_mantissa_reg != `LHS_ZERO8);
      rx_clk_on <= ~lin_slave |
                   (divider_mantissa_reg != `LHS_ZERO8);
    end
  end

endmodule

/* hdl/lhs_defines.vh */
`ifndef LHS_DEFINES_VH
`define LHS_DEFINES_VH

// Register offsets on the local port
`define LHS_OFF_STATUS  3'h0
`define LHS_OFF_BAUD    3'h2
`define LHS_OFF_CR3     3'h5
`define LHS_OFF_ERX     3'h6
`define LHS_OFF_ETX     3'h7

// Third control register bit positions
`define LHS_CR3_UPD     7
`define LHS_CR3_LIN     6
`define LHS_CR3_SLV     5
`define LHS_CR3_ASE     4
`define LHS_CR3_HDM     3
`define LHS_CR3_HIE     2
`define LHS_CR3_HDF     1
`define LHS_CR3_SF      0

// Reset and fill values
`define LHS_ZERO8       8'h00
`define LHS_ONES8       8'hff
`define LHS_ZERO4       4'h0
`define LHS_ZERO12      12'h000
`define LHS_ONES12      12'hfff

// Oversampling: sixteen ticks per bit
`define LHS_TICK_STEP   13'h0010
`define LHS_BREAK_LAST  8'haf
`define LHS_CHAR_TICKS  8'h98
`define LHS_SYNCH_EDGES 3'h5

// Header length coding in quarter bits
`define LHS_QROUND      13'h0002
`define LHS_HDR_MAX_Q   11'h0e4

`endif

/* hdl/lhs_sync.v */
// Two-stage synchroniser for the receive pin
module lhs_sync (
  input  wire clk,
  input  wire srst,
  input  wire din,
  output wire dout
);

  reg meta_reg;  // First stage, read only by second
  reg sync_reg;  // Second stage, safe to use

  // Idle line is recessive high
  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

/* hdl/lhs_baud.v */
`include "lhs_defines.vh"

// Fractional divider giving sixteen ticks per bit
module lhs_baud (
  input  wire        clk,
  input  wire        srst,
  input  wire [11:0] divider,
  output reg         tick
);

  reg  [11:0] acc_reg;  // Phase in sixteenths of a clock
  wire [12:0] sum;      // Phase after this clock
  wire        off;      // Zero mantissa stops the clock

  assign sum = {1'b0, acc_reg} + `LHS_TICK_STEP;
  assign off = (divider[11:4] == `LHS_ZERO8);

  // Tick whenever a whole divider period has built up
  always @(posedge clk) begin
    if (srst || off) begin
      acc_reg <= `LHS_ZERO12;
      tick    <= 1'b0;
    end else if (sum >= {1'b0, divider}) begin
      acc_reg <= sum[11:0] - divider;
      tick    <= 1'b1;
    end else begin
      acc_reg <= sum[11:0];
      tick    <= 1'b0;
    end
  end

endmodule

/* testbench/lhs_checker.sv */
// Port-level checks on the LIN slave header and divider block
module lhs_checker #(
  parameter [11:0] HDR_TIMEOUT_TICKS = 12'h4c0
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       serial_rx_input,
  input wire logic       sci_irq,
  input wire logic       tx_clk_on,
  input wire logic       rx_clk_on
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [7:0] cr3_reg;   // Shadow of control3
  reg  [7:0] mant_reg;  // Shadow of the mantissa
  wire       slv;       // Slave mode shadow

  assign slv = cr3_reg[6] & cr3_reg[5];

  // Shadows follow bus writes
  always @(posedge clk) begin
    if (srst) begin
      cr3_reg  <= 8'h00;
      mant_reg <= 8'h00;
    end else if (wr_en && addr == 3'h5) begin
      cr3_reg  <= wdata;
    end else if (wr_en && addr == 3'h2 && slv) begin
      mant_reg <= wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Software clear of synch state, then a control3 read
  sequence s_synch_clear;
    wr_en && addr == 3'h5 && !wdata[0];
  endsequence
  sequence s_cr3_read;
    rd_en && addr == 3'h5;
  endsequence

  a_clk_pair_equal: assert property (tx_clk_on == rx_clk_on)
    else $error("transmit and receive clock enables differ");
  a_clk_gate_mant: assert property (!$past(srst) && !$past(wr_en)
    |-> tx_clk_on == !(slv && mant_reg == 8'h00))
    else $error("clock enable does not follow zero mantissa");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(rd_en) && $past(addr) inside {0, 1, 3, 4}
    |-> rdata == 8'h00)
    else $error("unmapped or status read not zero");
  a_frac_upper: assert property ($past(rd_en) && $past(addr) == 3'h7 && slv
    |-> rdata[7:4] == 4'h0)
    else $error("fraction upper bits not zero");
  a_mant_readback: assert property ($past(rd_en) && $past(addr) == 3'h2 && slv
    |-> rdata == mant_reg)
    else $error("mantissa readback wrong");
  a_cr3_readback: assert property ($past(rd_en) && $past(addr) == 3'h5
    |-> rdata[7:2] == cr3_reg[7:2])
    else $error("control3 readback wrong");
  a_len_hidden: assert property ($past(rd_en) && $past(addr) == 3'h6 && slv
    && !cr3_reg[4] && !cr3_reg[3] |-> rdata == 8'h00)
    else $error("header length visible without auto or method");
  a_irq_enable: assert property (sci_irq |-> $past(slv && cr3_reg[2]))
    else $error("interrupt without enable");
  a_synch_sw_clear: assert property (s_synch_clear ##2 s_cr3_read |=> !rdata[0])
    else $error("synch state not cleared by software");
endmodule

bind lhs_top lhs_checker #(.HDR_TIMEOUT_TICKS(HDR_TIMEOUT_TICKS)) u_chk (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .serial_rx_input(serial_rx_input), .sci_irq(sci_irq),
  .tx_clk_on(tx_clk_on), .rx_clk_on(rx_clk_on));

/* testbench/lhs_lin_master.sv */
// LIN bus master driving the receive line, recessive high when idle
module lhs_lin_master #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  time last_at;  // Start of the latest level
  time brk_at;   // Start of the break
  time id_at;    // Start bit of the latest byte

  initial rx_line = 1'b1;

  // Hold one level for n bit times, changed just after an edge
  task automatic level(input logic v, input int n);
    @(posedge clk);
    last_at = $time;
    rx_line <= v;
    repeat (n * BIT_CLKS - 1) @(posedge clk);
  endtask

  // Dominant break then a one-bit delimiter
  task automatic brk(input int n);
    level(1'b0, n);
    brk_at = last_at;
    level(1'b1, 1);
  endtask

  // One byte, start bit, lsb first, stop bit
  task automatic send(input logic [7:0] b);
    level(1'b0, 1);
    id_at = last_at;
    for (int i = 0; i < 8; i++) level(b[i], 1);
    level(1'b1, 1);
  endtask
endmodule

/* testbench/testbench.sv */
// Register-level tests of the LIN slave header block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       srst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       serial_rx_input;
  logic       sci_irq;
  logic       tx_clk_on;
  logic       rx_clk_on;
  int         bad_count;
  int         comparisons;
  int         tk;

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  lhs_top #(.HDR_TIMEOUT_TICKS(12'h3a0)) u_dut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .serial_rx_input(serial_rx_input), .sci_irq(sci_irq),
    .tx_clk_on(tx_clk_on), .rx_clk_on(rx_clk_on));

  lhs_lin_master u_lin (.clk(clk), .rx_line(serial_rx_input));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Measured length may differ by one quarter step
  task automatic near(input string n, input int e, input logic [7:0] g);
    comparisons++;
    if (((g >= e - 1) && (g <= e + 1)) !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read strobe, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("clk on idle", 8'h03, {6'h0, tx_clk_on, rx_clk_on});
    for (int i = 0; i < 5; i++) if (i != 2) rc("unmapped", i[2:0], 8'h00);
    // Slave mode, divider programmed fraction first with whole bytes
    wr(3'h5, 8'h60);
    rc("mantissa reset", 3'h2, 8'h00);
    chk("clk off", 8'h00, {6'h0, tx_clk_on, rx_clk_on});
    wr(3'h7, 8'hf0);
    rc("fraction", 3'h7, 8'h00);
    wr(3'h2, 8'h01);
    rc("mantissa", 3'h2, 8'h01);
    chk("clk running", 8'h03, {6'h0, tx_clk_on, rx_clk_on});
    // Too short a break is ignored
    wr(3'h5, 8'h7c);
    u_lin.level(1'b0, 10);
    u_lin.level(1'b1, 2);
    rc("short break", 3'h5, 8'h7c);
    // Identifier method: break, synch, identifier
    u_lin.brk(13);
    rc("synch set", 3'h5, 8'h7d);
    rc("length ones", 3'h6, 8'hff);
    u_lin.send(8'h55);
    rc("synch done", 3'h5, 8'h7c);
    u_lin.send(8'h3c);
    tk = int'((u_lin.id_at - u_lin.brk_at) / 5) + 152;
    rc("flag set", 3'h5, 8'h7e);
    chk("irq", 8'h01, {7'h0, sci_irq});
    rd(3'h6, d);
    near("length", 228 - (tk + 2) / 4, d);
    rc("status", 3'h0, 8'h00);
    rc("flag held", 3'h5, 8'h7e);
    rc("flag clear", 3'h5, 8'h7c);
    @(posedge clk);
    #1 chk("irq off", 8'h00, {7'h0, sci_irq});
    // Break method with interrupt inhibited
    wr(3'h5, 8'h70);
    u_lin.brk(11);
    rc("break header", 3'h5, 8'h73);
    chk("irq inhibit", 8'h00, {7'h0, sci_irq});
    rd(3'h6, d);
    near("break length", 184, d);
    wr(3'h5, 8'h70);
    rc("synch cleared", 3'h5, 8'h72);
    wr(3'h0, 8'h00);
    rc("flag held", 3'h5, 8'h72);
    rc("flag clear", 3'h5, 8'h70);
    // Flag and synch bits cannot be set by software
    wr(3'h5, 8'he3);
    rc("control3 ro", 3'h5, 8'he0);
    rc("length hidden", 3'h6, 8'h00);
    // Break with no synch field runs into the header timeout
    wr(3'h5, 8'h7c);
    u_lin.brk(13);
    repeat (760) @(posedge clk);
    rc("timeout length", 3'h6, 8'h00);
    rc("timeout idle", 3'h5, 8'h7c);
    wr(3'h2, 8'h00);
    @(posedge clk);
    #1 chk("clk stop", 8'h00, {6'h0, tx_clk_on, rx_clk_on});
    summarize();
  end
endmodule
